// ==== muxio_parity_wait_bus_ctl.sv ====
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// Operation
// [R1] mux I/O enable makes area 6 with A27 clear a multiplexed address/data space
// [R2] A14 low: 8-bit bus, address and data on low eight pins
// [R3] A14 high: 16-bit bus, address and data on all sixteen pins
// [R4] mux access uses latch, read and write strobes, four base states always
// [R5] read strobe high for 50% or 35% of T3 and wait states by duty bit
// [R6] mux access samples wait input, adds a wait state while it reads low
// [R7] byte strobe select picks split write strobes plus A0, or common write plus byte strobes
// [R8] parity only in selected space, DRAM or DRAM plus area 2, chosen polarity
// [R9] reads check upper and lower parity pins per byte, error raises interrupt
// [R10] writes drive byte parity on both parity pins with data timing
// [R11] force bit drives both parity pins high on writes to parity space
// [R12] warp lets external write or DMA single cycle overlap internal accesses
// [R13] overlap only from second state of a multi-state external cycle
// [R14] areas 1,3-5,7 reads: one state no wait, or two plus waits
// [R15] areas 0,2,6 reads: one plus long wait, wait input only if bit set
// [R16] long wait count comes from long wait register, one to four states
// [R17] DRAM area 1 column cycle: one state short pitch, two plus waits long
// [R18] writes: areas 1,3-5,7 two plus waits; 0,2,6 one plus long plus waits
// [R19] on-chip peripheral space always three states, no wait sampling
// [R20] on-chip ROM and RAM always one state, no wait sampling
// [R21] outside parity space no check, no interrupt, parity pins undriven
module muxio_parity_wait_bus_ctl
    import muxio_parity_wait_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // internal bus masters
    input wire bus_req_s req,
    output bus_resp_s resp,
    input wire logic internal_req,
    output logic internal_grant,
    // external bus pins
    input wire logic [15:0] mux_addr_data_pins_in,
    output logic [15:0] mux_addr_data_pins_out,
    output logic [15:0] mux_addr_data_pins_oe,
    input wire logic upper_parity_pin_in,
    output logic upper_parity_pin_out,
    output logic upper_parity_pin_oe,
    input wire logic lower_parity_pin_in,
    output logic lower_parity_pin_out,
    output logic lower_parity_pin_oe,
    output logic address_latch_strobe_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic high_byte_write_strobe_n,
    output logic low_byte_write_strobe_n,
    output logic high_byte_strobe_n,
    output logic low_byte_strobe_n,
    output logic addr_bit0,
    input wire logic wait_n,
    input wire logic [2:0] boot_mode_pins,
    // events
    output logic parity_error_irq
);

    typedef struct packed {
        bus_state_e st;
        logic [4:0] tick;
        logic [2:0] bidx;
        logic [2:0] nbase;
        logic [2:0] wchk;
        logic wen;
        logic in_wait;
        logic is_mux;
        logic wide;
        logic wr;
        logic dma1;
        logic par_on;
        logic [1:0] be;
        logic [27:0] addr;
        logic [15:0] wdata;
        logic [4:0] bus_control_reg;
        logic [3:0] parity_control_reg;
        logic [7:0] read_wait_bits;
        logic write_wait_select_bit;
        logic [1:0] long_wait_count;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [2:0] wait_s;
        logic wait_f;
        logic [2:0][2:0] boot_s;
        logic [1:0] boot_cnt;
        logic boot_ok;
        logic [2:0] boot_q;
        logic [2:0][17:0] din_s;
        logic done;
        logic [15:0] rdata;
        logic perr_irq;
        logic [1:0] parerr;
        logic grant;
        logic [15:0] pin_o;
        logic [15:0] pin_oe;
        logic dph_o;
        logic dpl_o;
        logic dp_oe;
        logic latch_n;
        logic rd_n;
        logic wr_n;
        logic wrh_n;
        logic wrl_n;
        logic hbs_n;
        logic lbs_n;
        logic a0;
        logic [3:0] sc;
        logic [3:0] wc;
    } ctl_s;

    localparam ctl_s CTL_RST = '{st: ST_IDLE, bus_control_reg: BUS_CONTROL_RST,
        parity_control_reg: PARITY_CONTROL_RST, read_wait_bits: READ_WAIT_RST,
        write_wait_select_bit: WRITE_WAIT_RST, long_wait_count: LONG_WAIT_RST,
        wait_s: 3'h7, wait_f: 1'b1, latch_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, wrh_n: 1'b1,
        wrl_n: 1'b1, hbs_n: 1'b1, lbs_n: 1'b1, default: '0};

    ctl_s q;
    ctl_s d;

    function automatic logic byte_par(input logic [7:0] b, input logic odd);
        byte_par = (^b) ^ odd;
    endfunction

    always_comb begin
        logic [2:0] area;
        logic a27;
        logic is_dram;
        logic [2:0] lw;
        logic [2:0] nb;
        logic we;
        logic busy;
        logic dphase;
        logic strobe_ph;
        logic rd_high;
        logic wr_act;
        logic rd_act;
        logic odd;
        logic [17:0] din;
        logic e_hi;
        logic e_lo;
        area = req.addr[22:20];
        a27 = req.addr[27];
        is_dram = area == AREA_DRAM && q.bus_control_reg[BC_DRAM];
        lw = 3'(q.long_wait_count) + 3'h1; // R16
        nb = N_ONE;
        we = 1'b0;
        busy = q.st == ST_RUN;
        dphase = !q.is_mux || q.bidx != 3'h0 || q.in_wait;
        strobe_ph = !q.is_mux || q.bidx == 3'h1 || q.bidx == 3'h2 || q.in_wait;
        rd_high = q.is_mux && (q.bidx == 3'h2 || q.in_wait) && q.tick >=
            (q.bus_control_reg[BC_RD_DUTY] ? RD_HIGH_FROM_35 : RD_HIGH_FROM_50); // R5
        wr_act = busy && q.wr && strobe_ph;
        rd_act = busy && !q.wr && strobe_ph && !rd_high;
        odd = q.parity_control_reg[PC_POLARITY];
        din = q.din_s[2];
        e_hi = din[17] != byte_par(din[15:8], odd);
        e_lo = din[16] != byte_par(din[7:0], odd);
        d = q;

        // pin synchronisers; first stage feeds only the second
        d.wait_s = {q.wait_s[1:0], wait_n};
        if (q.wait_s[1] == q.wait_s[2]) begin
            d.wait_f = q.wait_s[2];
        end
        d.boot_s = {q.boot_s[1:0], boot_mode_pins};
        d.din_s = {q.din_s[1:0], {upper_parity_pin_in, lower_parity_pin_in, mux_addr_data_pins_in}};
        if (!q.boot_ok) begin
            if (q.boot_cnt != BOOT_SETTLE_CYC) begin
                d.boot_cnt = q.boot_cnt + 2'h1;
            end else if (q.boot_s[1] == q.boot_s[2]) begin
                d.boot_q = q.boot_s[2];
                d.boot_ok = 1'b1;
            end
        end

        // apb: read data loaded first access cycle, write lands when pready is sampled
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        if (psel && penable && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = 32'h0000_0000;
            if (paddr == OFS_BUS_CONTROL) begin
                d.prdata[4:0] = q.bus_control_reg;
            end else if (paddr == OFS_PARITY_CONTROL) begin
                d.prdata[3:0] = q.parity_control_reg;
            end else if (paddr == OFS_READ_WAIT) begin
                d.prdata[7:0] = q.read_wait_bits;
            end else if (paddr == OFS_WRITE_WAIT) begin
                d.prdata[0] = q.write_wait_select_bit;
            end else if (paddr == OFS_LONG_WAIT) begin
                d.prdata[1:0] = q.long_wait_count;
            end else if (paddr == OFS_STATUS) begin
                d.prdata[11:0] = {q.parerr, q.boot_q, q.wait_f, q.in_wait, q.bidx, q.grant, busy};
            end else begin
                d.pslverr = 1'b1;
            end
        end
        if (psel && penable && q.pready && pwrite) begin
            if (paddr == OFS_BUS_CONTROL) begin
                d.bus_control_reg = pwdata[4:0];
            end else if (paddr == OFS_PARITY_CONTROL) begin
                d.parity_control_reg = pwdata[3:0];
            end else if (paddr == OFS_READ_WAIT) begin
                d.read_wait_bits = pwdata[7:0];
            end else if (paddr == OFS_WRITE_WAIT) begin
                d.write_wait_select_bit = pwdata[0];
            end else if (paddr == OFS_LONG_WAIT) begin
                d.long_wait_count = pwdata[1:0];
            end
        end

        // bus cycle sequencer
        d.done = 1'b0;
        d.perr_irq = 1'b0;
        case (q.st)
            ST_IDLE: begin
                if (req.valid && !q.done) begin
                    d.is_mux = 1'b0;
                    if (area == AREA_PERIPH && a27) begin
                        nb = N_PERIPH; // R19
                    end else if ((area == AREA_ROM && q.boot_q == MODE_ONCHIP_ROM) ||
                        (area == AREA_RAM && !a27)) begin
                        nb = N_ONE; // R20
                    end else if (area == AREA_MUX && !a27 && q.bus_control_reg[BC_MUX_IO]) begin
                        nb = N_MUX; // R4
                        we = 1'b1; // R6
                        d.is_mux = 1'b1; // R1
                    end else if (is_dram) begin
                        we = req.write ? q.write_wait_select_bit : q.read_wait_bits[AREA_DRAM];
                        nb = we ? N_TWO : N_ONE; // R17
                    end else if (area == AREA_ROM || area == AREA_PAR2 || area == AREA_MUX) begin
                        nb = 3'(lw + 3'h1); // R15
                        we = req.write || q.read_wait_bits[area]; // R18
                    end else if (req.write) begin
                        nb = N_TWO; // R18
                        we = 1'b1;
                    end else begin
                        we = q.read_wait_bits[area];
                        nb = we ? N_TWO : N_ONE; // R14
                    end
                    d.st = ST_RUN;
                    d.nbase = nb;
                    d.wchk = 3'(nb - 3'h2);
                    d.wen = we && nb >= N_TWO;
                    d.wide = req.addr[14]; // R2 R3
                    d.wr = req.write;
                    d.dma1 = req.dma_single;
                    d.be = req.be;
                    d.addr = req.addr;
                    d.wdata = req.wdata;
                    d.par_on = (q.parity_control_reg[PC_SPACE_LO] ||
                        q.parity_control_reg[PC_SPACE_HI]) && is_dram ||
                        q.parity_control_reg[PC_SPACE_HI] && area == AREA_PAR2 && !a27; // R8
                    d.tick = 5'h00;
                    d.bidx = 3'h0;
                    d.in_wait = 1'b0;
                    d.sc = 4'h0;
                    d.wc = 4'h0;
                end
            end
            ST_RUN: begin
                if (q.tick == TICK_LAST) begin
                    d.tick = 5'h00;
                    d.sc = q.sc + 4'h1;
                    if (q.wen && q.bidx == q.wchk && !q.wait_f) begin
                        d.in_wait = 1'b1; // R6
                        d.wc = q.wc + 4'h1;
                    end else begin
                        d.in_wait = 1'b0;
                        if (q.bidx == 3'(q.nbase - 3'h1)) begin
                            d.st = ST_IDLE;
                            d.done = 1'b1;
                            if (!q.wr) begin
                                d.rdata = (q.is_mux && !q.wide) ? {8'h00, din[7:0]} : din[15:0];
                            end
                            if (!q.wr && q.par_on) begin
                                d.parerr = {e_hi, e_lo}; // R9
                                d.perr_irq = e_hi || e_lo; // R9
                            end
                        end else begin
                            d.bidx = q.bidx + 3'h1;
                        end
                    end
                end else begin
                    d.tick = q.tick + 5'h01;
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // pin drive, registered so every pin leaves a flip-flop
        d.latch_n = !(busy && q.is_mux && q.bidx == 3'h0 && !q.in_wait); // R4
        d.pin_o = 16'h0000;
        d.pin_oe = 16'h0000;
        if (busy && q.is_mux && q.bidx == 3'h0) begin
            d.pin_o = q.wide ? q.addr[15:0] : {8'h00, q.addr[7:0]}; // R2 R3
            d.pin_oe = q.wide ? 16'hFFFF : 16'h00FF; // R2 R3
        end else if (busy && q.wr && dphase) begin
            d.pin_o = q.wdata;
            d.pin_oe = (q.is_mux && !q.wide) ? 16'h00FF : 16'hFFFF;
        end
        d.rd_n = !rd_act; // R5
        if (q.bus_control_reg[BC_BYTE_SEL]) begin
            d.wr_n = !wr_act; // R7
            d.hbs_n = !((wr_act || rd_act) && q.be[1]);
            d.lbs_n = !((wr_act || rd_act) && q.be[0]);
            d.wrh_n = 1'b1;
            d.wrl_n = 1'b1;
        end else begin
            d.wr_n = 1'b1;
            d.hbs_n = 1'b1;
            d.lbs_n = 1'b1;
            d.wrh_n = !(wr_act && q.be[1]); // R7
            d.wrl_n = !(wr_act && q.be[0]);
        end
        d.a0 = busy && q.addr[0];
        // parity pins float outside the parity space
        d.dp_oe = busy && q.wr && q.par_on && dphase; // R10 R21
        d.dph_o = d.dp_oe && (q.parity_control_reg[PC_FORCE] || byte_par(q.wdata[15:8], odd)); // R10 R11
        d.dpl_o = d.dp_oe && (q.parity_control_reg[PC_FORCE] || byte_par(q.wdata[7:0], odd)); // R10 R11
        // warp: first external state runs alone so the address phase is never shared
        d.grant = internal_req && ((q.st == ST_IDLE && !(req.valid && !q.done)) ||
            (q.bus_control_reg[BC_WARP] && busy && (q.wr || q.dma1) &&
            (q.bidx != 3'h0 || q.in_wait))); // R12 R13
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= CTL_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign resp = '{done: q.done, rdata: q.rdata};
    assign internal_grant = q.grant;
    assign mux_addr_data_pins_out = q.pin_o;
    assign mux_addr_data_pins_oe = q.pin_oe;
    assign upper_parity_pin_out = q.dph_o;
    assign lower_parity_pin_out = q.dpl_o;
    assign upper_parity_pin_oe = q.dp_oe;
    assign lower_parity_pin_oe = q.dp_oe;
    assign address_latch_strobe_n = q.latch_n;
    assign read_strobe_n = q.rd_n;
    assign write_strobe_n = q.wr_n;
    assign high_byte_write_strobe_n = q.wrh_n;
    assign low_byte_write_strobe_n = q.wrl_n;
    assign high_byte_strobe_n = q.hbs_n;
    assign low_byte_strobe_n = q.lbs_n;
    assign addr_bit0 = q.a0;
    assign parity_error_irq = q.perr_irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_latch_mux_only: assert property (!address_latch_strobe_n |-> $past(q.is_mux && q.st == ST_RUN)) // R1
        else $error("latch strobe outside mux access");
    a_narrow_lanes: assert property ($past(q.st == ST_RUN && q.is_mux && !q.wide)
        |-> mux_addr_data_pins_oe[15:8] == 8'h00) // R2
        else $error("upper lanes driven on 8-bit mux access");
    a_wide_address: assert property ((q.st == ST_RUN && q.is_mux && q.wide && q.bidx == 3'h0)
        |=> mux_addr_data_pins_oe == 16'hFFFF) // R3
        else $error("16-bit mux address not on all pins");
    a_mux_four_states: assert property (q.done && q.is_mux |-> q.sc == 4'(q.wc + 4'h4)) // R4
        else $error("mux access not four states plus waits");
    a_rd_duty_high: assert property ((q.st == ST_RUN && q.is_mux && !q.wr && q.bidx == 3'h2 &&
        q.tick == (q.bus_control_reg[BC_RD_DUTY] ? RD_HIGH_FROM_35 : RD_HIGH_FROM_50))
        |=> read_strobe_n ##1 !$past(read_strobe_n, 2)) // R5
        else $error("read strobe duty window wrong");
    a_mux_wait_insert: assert property ((q.st == ST_RUN && q.is_mux && q.bidx == 3'h2 &&
        q.tick == TICK_LAST && !q.wait_f) |=> q.in_wait && q.bidx == 3'h2) // R6
        else $error("wait low did not insert a wait state");
    a_byte_mode_split: assert property (q.bus_control_reg[BC_BYTE_SEL] && $past(q.bus_control_reg[BC_BYTE_SEL])
        |-> high_byte_write_strobe_n && low_byte_write_strobe_n) // R7
        else $error("split write strobes active in byte strobe mode");
    a_parity_force: assert property (upper_parity_pin_oe && $past(q.parity_control_reg[PC_FORCE])
        |-> upper_parity_pin_out && lower_parity_pin_out) // R11
        else $error("forced parity not high");
    a_parity_float: assert property (!$past(q.par_on && q.wr && q.st == ST_RUN)
        |-> !upper_parity_pin_oe && !lower_parity_pin_oe) // R21
        else $error("parity pins driven outside parity space");
    a_irq_space: assert property (parity_error_irq |-> $past(q.par_on && !q.wr)) // R9
        else $error("parity interrupt outside checked read");
    a_periph_three: assert property ((q.st == ST_IDLE && req.valid && !q.done &&
        req.addr[22:20] == AREA_PERIPH && req.addr[27]) |=> q.nbase == N_PERIPH && !q.wen) // R19
        else $error("peripheral access not three fixed states");
    a_warp_first_alone: assert property ($past(q.st == ST_RUN && q.bidx == 3'h0 && !q.in_wait)
        |-> !internal_grant) // R13
        else $error("internal access overlapped first external state");

    c_mux_wait: cover property (q.is_mux && q.in_wait ##[1:200] q.done);
    c_parity_error: cover property (parity_error_irq);
    c_warp_overlap: cover property (internal_grant && q.st == ST_RUN);
    c_long_wait_four: cover property (q.done && q.nbase == 3'h5);

endmodule // muxio_parity_wait_bus_ctl

// ==== muxio_parity_wait_pkg.sv ====
package muxio_parity_wait_pkg;

    // bus timing: one bus state spans STATE_CYC pclk cycles
    localparam int STATE_NS = 80;
    localparam int PCLK_NS = 4;
    localparam int STATE_CYC = STATE_NS / PCLK_NS;
    localparam logic [4:0] TICK_LAST = 5'(STATE_CYC - 1);
    localparam int DUTY50_CYC = STATE_CYC / 2;
    localparam int DUTY35_CYC = (STATE_CYC * 35) / 100;
    localparam logic [4:0] RD_HIGH_FROM_50 = 5'(STATE_CYC - DUTY50_CYC);
    localparam logic [4:0] RD_HIGH_FROM_35 = 5'(STATE_CYC - DUTY35_CYC);
    localparam logic [1:0] BOOT_SETTLE_CYC = 2'h3;

    // register byte offsets
    localparam logic [11:0] OFS_BUS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_PARITY_CONTROL = 12'h004;
    localparam logic [11:0] OFS_READ_WAIT = 12'h008;
    localparam logic [11:0] OFS_WRITE_WAIT = 12'h00C;
    localparam logic [11:0] OFS_LONG_WAIT = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;

    // bus_control_reg fields
    localparam int BC_MUX_IO = 0;
    localparam int BC_RD_DUTY = 1;
    localparam int BC_BYTE_SEL = 2;
    localparam int BC_WARP = 3;
    localparam int BC_DRAM = 4;
    // parity_control_reg fields
    localparam int PC_SPACE_LO = 0;
    localparam int PC_SPACE_HI = 1;
    localparam int PC_POLARITY = 2;
    localparam int PC_FORCE = 3;

    localparam logic [4:0] BUS_CONTROL_RST = 5'h00;
    localparam logic [3:0] PARITY_CONTROL_RST = 4'h0;
    localparam logic [7:0] READ_WAIT_RST = 8'hFF;
    localparam logic WRITE_WAIT_RST = 1'b1;
    localparam logic [1:0] LONG_WAIT_RST = 2'h3;

    // area decode and base state counts
    localparam logic [2:0] AREA_ROM = 3'h0;
    localparam logic [2:0] AREA_DRAM = 3'h1;
    localparam logic [2:0] AREA_PAR2 = 3'h2;
    localparam logic [2:0] AREA_PERIPH = 3'h5;
    localparam logic [2:0] AREA_MUX = 3'h6;
    localparam logic [2:0] AREA_RAM = 3'h7;
    localparam logic [2:0] MODE_ONCHIP_ROM = 3'h2;
    localparam logic [2:0] N_ONE = 3'h1;
    localparam logic [2:0] N_TWO = 3'h2;
    localparam logic [2:0] N_PERIPH = 3'h3;
    localparam logic [2:0] N_MUX = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } bus_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic dma_single;
        logic [1:0] be;
        logic [27:0] addr;
        logic [15:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic done;
        logic [15:0] rdata;
    } bus_resp_s;

endpackage

// ==== mux_periph_model.sv ====
`timescale 1ns/10ps
module mux_periph_model (
    // clock and strobes seen
    input wire logic pclk,
    input wire logic als_n,
    input wire logic rd_n,
    // bench knobs
    input wire logic [1:0] nwait,
    input wire logic [15:0] rdat,
    input wire logic pol,
    input wire logic bad,
    // toward device
    output logic [15:0] ad_in,
    output logic up_in,
    output logic lo_in,
    output logic wait_n
);
    int sl = 1000;
    int sr = 1000;
    logic dv;
    logic pu;
    logic pl;
    always @(posedge pclk) begin
        sl <= !als_n ? 0 : (sl < 1000 ? sl + 1 : 1000);
        sr <= !rd_n ? 0 : (sr < 1000 ? sr + 1 : 1000);
    end
    // low past every sample point wanted, margin for input sync
    assign wait_n = !(nwait != 2'h0 && sl < 20 * int'(nwait) + 30);
    // hold past the end of T4 and the input sync, then inverted so stale data never matches
    assign dv = sr < 48;
    assign pu = ^rdat[15:8] ^ pol ^ bad;
    assign pl = ^rdat[7:0] ^ pol ^ bad;
    assign ad_in = dv ? rdat : ~rdat;
    assign up_in = dv ? pu : !pu;
    assign lo_in = dv ? pl : !pl;
endmodule // mux_periph_model

// ==== muxio_parity_wait_bus_ctl_tb_top.sv ====
`timescale 1ns/10ps
module muxio_parity_wait_bus_ctl_tb_top import muxio_parity_wait_pkg::*; ;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, internal_req = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    bus_req_s req = '0;
    bus_resp_s resp;
    logic [15:0] ao, ae, am, aw, lat_v, wr_v, rdat = 16'h0, d, rd;
    logic uo, ue, lo, le, um, lm, als_n, rd_n, wr_n, irq, gr, pol = 0, bad = 0, e, ps, uv, lv, iv, gv, ge, wr, a14, wn;
    logic [1:0] nwait = 2'h0;
    logic [27:0] a;
    int errors = 0, check_count = 0, n, rl, st;
    assign aw = (ae & ao) | (~ae & am);
    muxio_parity_wait_bus_ctl muxio_parity_wait_bus_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req(req), .resp(resp), .internal_req(internal_req), .internal_grant(gr),
        .mux_addr_data_pins_in(aw), .mux_addr_data_pins_out(ao), .mux_addr_data_pins_oe(ae),
        .upper_parity_pin_in(ue ? uo : um), .upper_parity_pin_out(uo), .upper_parity_pin_oe(ue),
        .lower_parity_pin_in(le ? lo : lm), .lower_parity_pin_out(lo), .lower_parity_pin_oe(le),
        .address_latch_strobe_n(als_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .high_byte_write_strobe_n(), .low_byte_write_strobe_n(), .high_byte_strobe_n(), .low_byte_strobe_n(),
        .addr_bit0(), .wait_n(wn), .boot_mode_pins(3'h0), .parity_error_irq(irq));
    mux_periph_model mux_periph_model_inst (.pclk(pclk), .als_n(als_n), .rd_n(rd_n), .nwait(nwait),
        .rdat(rdat), .pol(pol), .bad(bad), .ad_in(am), .up_in(um), .lo_in(lm), .wait_n(wn));
    initial forever #2 pclk = ~pclk;
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic xfer(input logic w, input logic [27:0] ad, input logic [15:0] wd);
        @(posedge pclk);
        req <= '{valid: 1'b1, write: w, dma_single: 1'b0, be: 2'b11, addr: ad, wdata: wd};
        {lat_v, wr_v, ps, iv, gv, ge} = '0;
        n = 0;
        rl = 0;
        do begin
            @(posedge pclk);
            n++;
            if (!als_n) lat_v = ao & ae;
            if (!wr_n) wr_v = ao & ae;
            if (!rd_n) rl++;
            if (ue) {ps, uv, lv} = {1'b1, uo, lo};
            if (irq) iv = 1;
            if (gr && n > 30 && n < 60) gv = 1;
            if (gr && n > 3 && n < 18) ge = 1;
        end while (resp.done !== 1'b1 && n < 3000);
        rd = resp.rdata;
        req <= '0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #80000;
        errors++;
        give_verdict;
    end
    initial begin
        void'($urandom(68));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        repeat (8) @(posedge pclk);
        apb(0, OFS_READ_WAIT, 0);
        check(r, 32'h0000_00FF);
        apb(0, OFS_LONG_WAIT, 0);
        check(r, 32'h3);
        apb(0, 12'h018, 0);
        check(r, 32'h0);
        check(32'(e), 32'h1);
        $display("registers done");
        for (int k = 0; k < 2; k++) begin
            apb(1, OFS_BUS_CONTROL, 32'(5 + 2 * k));
            for (int i = 0; i < 8; i++) begin
                {a14, wr} = 2'(i);
                nwait = i[2] ? 2'(1 + $urandom % 2) : 2'h0;
                d = 16'($urandom);
                rdat = 16'($urandom);
                a = 28'h0600000 | 28'({a14, 14'($urandom)});
                xfer(wr, a, d);
                check(n, (4 + nwait) * 20 + 2);
                check(lat_v, a14 ? a[15:0] : {8'h00, a[7:0]});
                if (wr) check(wr_v, a14 ? d : {8'h00, d[7:0]});
                else check({rd, rl}, {a14 ? rdat : {8'h00, rdat[7:0]}, 32'(20 + (k ? 13 : 10) * (1 + nwait))});
            end
        end
        nwait = 2'h0;
        $display("mux done");
        for (int c = 0; c < 6; c++) begin
            if (c < 4) apb(1, OFS_LONG_WAIT, c);
            if (c > 3) apb(1, OFS_READ_WAIT, c == 4 ? 32'h0 : 32'hFF);
            xfer(0, c < 4 ? 28'h0200000 : 28'h0300000, 0);
            check(n, (c < 4 ? 2 + c : c - 3) * 20 + 2);
        end
        nwait = 2'h2;
        xfer(0, 28'h8500000, 0);
        check(n, 62);
        xfer(1, 28'h0700000, 0);
        check(n, 22);
        nwait = 2'h0;
        $display("timing done");
        for (int j = 0; j < 8; j++) begin
            {pol, st} = {j[1], j[0] ? 32'h2 : 32'h1};
            apb(1, OFS_PARITY_CONTROL, 32'({j[2], j[1]} * 4 + st));
            d = 16'($urandom);
            xfer(1, 28'h0200000, d);
            if (j[0]) check({ps, uv, lv}, {1'b1, j[2] | (^d[15:8] ^ pol), j[2] | (^d[7:0] ^ pol)});
            else check(ps, 0);
            {bad, rdat} = 17'($urandom);
            xfer(0, 28'h0200000, 0);
            check(iv, j[0] & bad);
        end
        bad = 0;
        $display("parity done");
        internal_req <= 1;
        for (int w = 0; w < 2; w++) begin
            apb(1, OFS_BUS_CONTROL, 32'(1 + 8 * w));
            xfer(1, 28'h0600000, 16'h00A5);
            check({ge, gv}, {1'b0, w[0]});
        end
        $display("warp done");
        give_verdict;
    end
endmodule // muxio_parity_wait_bus_ctl_tb_top
